/* File: rju_jump_unit.sv */
// Execution logic for the register jump and the relative jump.
// Assumes a register file read port that answers combinationally on the same clock,
// and a program counter that loads the target on the one-cycle write strobe.
//
// Contract
// - A register jump loads the program counter from the register named by its source register field.
// - A register jump clears bit zero of the target whatever the register holds.
// - A relative jump adds the sign-extended 22-bit displacement to the program counter and loads the sum.
// - Bit zero of the relative displacement is taken as zero so target bit zero equals program counter bit zero.
// - The program counter added is the address of the relative jump instruction itself.
// - A relative jump with zero displacement targets its own address.
// - The displacement is assembled from the word, its stored bits giving only the upper 21 of 22 bits.
`timescale 1ns/10ps
module rju_jump_unit #(
  parameter int unsigned XLEN = 32
) (
  input  wire logic              clk_i,        // Core clock, 10 MHz.
  input  wire logic              srst_i,       // Synchronous reset, active high.
  input  wire rju_pkg::rju_req_t req_i,        // Instruction word, its address and valid.
  output logic                   ready_o,      // High when a new instruction may be taken.
  output logic [4:0]             rf_raddr_o,   // Register file read address.
  input  wire logic [31:0]       rf_rdata_i,   // Register file read data for rf_raddr_o.
  output rju_pkg::rju_pc_t       pc_o,         // Program counter write strobe and target.
  output rju_pkg::rju_kind_t     kind_o,       // Kind of the last retired jump.
  output logic                   size32_o,     // Last retired jump was two halfwords.
  output logic                   other_o,      // Pulse: word was not a jump handled here.
  output logic                   flag_we_o     // Flag write strobe, never raised.
);

  // ********************************************
  // Elaboration checks
  // ********************************************
  if (XLEN != rju_pkg::WORD_W) begin : g_bad_xlen
    $error("rju_jump_unit serves a 32-bit word only");
  end

  // ********************************************
  // Decode
  // ********************************************
  function automatic logic is_regjump(input logic [31:0] w);
    return w[rju_pkg::RJ_OP_HI:rju_pkg::RJ_OP_LO] == rju_pkg::RJ_OPCODE;
  endfunction : is_regjump

  function automatic logic is_reljump(input logic [31:0] w);
    return w[rju_pkg::RL_OP_HI:rju_pkg::RL_OP_LO] == rju_pkg::RL_OPCODE;
  endfunction : is_reljump

  // Bit zero is supplied as zero, so no stored bit can make the target odd.
  function automatic logic [31:0] rel_disp(input logic [31:0] w);
    logic [rju_pkg::DISP_W-1:0] d;
    d = {w[rju_pkg::DHI_HI:rju_pkg::DHI_LO], w[rju_pkg::DLO_HI:rju_pkg::DLO_LO], 1'b0};
    return {{(rju_pkg::WORD_W - rju_pkg::DISP_W){d[rju_pkg::DISP_W-1]}}, d};
  endfunction : rel_disp

  typedef enum logic {
    ST_IDLE,
    ST_READ
  } rju_state_t;

  rju_state_t state_q;
  logic       take;
  logic       take_reg;
  logic       take_rel;

  assign take     = req_i.valid && ready_o;
  assign take_reg = take && is_regjump(req_i.word);
  assign take_rel = take && is_reljump(req_i.word);

  // ********************************************
  // Sequencing
  // ********************************************
  // A register jump spends one extra cycle so the register file is read from a registered address.
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      state_q <= ST_IDLE;
      ready_o <= 1'b0;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          ready_o <= !take_reg;
          if (take_reg) begin
            state_q <= ST_READ;
          end
        end
        ST_READ: begin
          state_q <= ST_IDLE;
          ready_o <= 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      rf_raddr_o <= '0;
    end else if (take_reg) begin
      rf_raddr_o <= req_i.word[rju_pkg::SRC_HI:rju_pkg::SRC_LO];
    end
  end

  // ********************************************
  // Program counter update
  // ********************************************
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      pc_o <= '0;
    end else if (state_q == ST_READ) begin
      pc_o.we     <= 1'b1;
      pc_o.target <= rf_rdata_i & rju_pkg::ALIGN_MASK;
    end else if (take_rel) begin
      pc_o.we     <= 1'b1;
      pc_o.target <= req_i.pc + rel_disp(req_i.word);
    end else begin
      pc_o.we     <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      kind_o   <= rju_pkg::RJU_KIND_NONE;
      size32_o <= 1'b0;
      other_o  <= 1'b0;
    end else begin
      other_o <= take && !is_regjump(req_i.word) && !is_reljump(req_i.word);
      if (take_reg) begin
        kind_o   <= rju_pkg::RJU_KIND_REG;
        size32_o <= 1'b0;
      end else if (take_rel) begin
        kind_o   <= rju_pkg::RJU_KIND_REL;
        size32_o <= 1'b1;
      end
    end
  end

  // Neither jump writes condition or saturation flags.
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      flag_we_o <= 1'b0;
    end else begin
      flag_we_o <= 1'b0;
    end
  end

  // ********************************************
  // Assertions
  // ********************************************
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (srst_i);

  sequence s_reg_take;
    take_reg;
  endsequence

  sequence s_reg_busy;
    !ready_o ##1 ready_o;
  endsequence

  sequence s_rel_take;
    take_rel;
  endsequence

  // Reset disables every property, so the first edge after release is judged on the values
  // that reset left behind; no property may therefore expect a jump in that cycle.
  // The register jump is judged over three edges: take, read and load.
  a_regjump_addr_load: assert property (s_reg_take |=>
      rf_raddr_o == $past(req_i.word[rju_pkg::SRC_HI:rju_pkg::SRC_LO]))
    else $error("register jump read address does not match source field");

  a_regjump_early_load: assert property (s_reg_take |=> !pc_o.we)
    else $error("register jump loaded the program counter before the read");

  a_raddr_holds_still: assert property (!take_reg |=> $stable(rf_raddr_o))
    else $error("read address changed without a register jump");

  a_regjump_target_value: assert property (s_reg_take ##1 1'b1 |=>
      pc_o.we && pc_o.target[31:1] == $past(rf_rdata_i[31:1]))
    else $error("register jump target differs from register content");

  a_regjump_lsb_clear: assert property (s_reg_take ##2 pc_o.we |-> !pc_o.target[0])
    else $error("register jump target is odd");

  a_regjump_busy_slot: assert property (s_reg_take |=> s_reg_busy)
    else $error("register jump did not hold off exactly one cycle");

  a_regjump_kind_mark: assert property (s_reg_take |=> kind_o == rju_pkg::RJU_KIND_REG && !size32_o)
    else $error("register jump not marked as a single halfword jump");

  a_reljump_sum_load: assert property (s_rel_take |=>
      pc_o.we && pc_o.target == $past(req_i.pc) + {{10{$past(req_i.word[5])}},
      $past(req_i.word[5:0]), $past(req_i.word[31:17]), 1'b0})
    else $error("relative jump target is not pc plus displacement");

  a_reljump_no_stall: assert property (s_rel_take |=> ready_o)
    else $error("relative jump held off the next instruction");

  a_reljump_kind_mark: assert property (s_rel_take |=> kind_o == rju_pkg::RJU_KIND_REL && size32_o)
    else $error("relative jump not marked as a two halfword jump");

  a_reljump_even_disp: assert property (take_rel |=> pc_o.target[0] == $past(req_i.pc[0]))
    else $error("relative jump displacement bit zero was used");

  a_reljump_own_base: assert property (take_rel && req_i.word[5:0] == 6'h00 && req_i.word[31:17] == 15'h0000
      |=> pc_o.target == $past(req_i.pc))
    else $error("zero displacement does not loop to own address");

  a_reljump_self_pc: assert property (take_rel |=>
      pc_o.target - $past(req_i.pc) == rel_disp($past(req_i.word)))
    else $error("relative jump base is not the instruction address");

  // The top stored bit is the sign: a negative offset lies in the top 2 MiB of the wrapped range.
  a_reljump_disp_sign: assert property (take_rel |=>
      (pc_o.target - $past(req_i.pc) >= 32'hffe0_0000) == $past(req_i.word[5]))
    else $error("relative jump offset has the wrong sign");

  a_flags_untouched: assert property (pc_o.we |-> !flag_we_o [*2])
    else $error("jump wrote a flag");

  a_other_no_jump: assert property (take && !is_regjump(req_i.word) && !is_reljump(req_i.word)
      |=> other_o && !pc_o.we)
    else $error("unknown word changed the program counter");

  a_other_keeps_kind: assert property (take && !is_regjump(req_i.word) && !is_reljump(req_i.word)
      |=> $stable(kind_o))
    else $error("unknown word changed the retired jump kind");

endmodule : rju_jump_unit

/* File: rju_pkg.sv */
// Package for the register and relative jump unit.
// Assumes a 32-bit core that fetches instructions as halfword pairs, low halfword first.
package rju_pkg;

  // ********************************************
  // Widths
  // ********************************************
  localparam int unsigned WORD_W  = 32;
  localparam int unsigned REG_W   = 5;
  localparam int unsigned DISP_W  = 22;

  // ********************************************
  // Encoding fields
  // ********************************************
  // Register jump: bits [15:5] carry a fixed pattern, bits [4:0] the source register field.
  localparam int unsigned RJ_OP_HI   = 15;
  localparam int unsigned RJ_OP_LO   = 5;
  localparam logic [10:0] RJ_OPCODE  = 11'h003;
  localparam int unsigned SRC_HI     = 4;
  localparam int unsigned SRC_LO     = 0;
  // Relative jump: bits [15:6] fixed, bits [5:0] displacement [21:16], bits [31:17] displacement [15:1].
  localparam int unsigned RL_OP_HI   = 15;
  localparam int unsigned RL_OP_LO   = 6;
  localparam logic [9:0]  RL_OPCODE  = 10'h01e;
  localparam int unsigned DHI_HI     = 5;
  localparam int unsigned DHI_LO     = 0;
  localparam int unsigned DLO_HI     = 31;
  localparam int unsigned DLO_LO     = 17;
  localparam logic [31:0] ALIGN_MASK = 32'hffff_fffe;

  // ********************************************
  // Carriers
  // ********************************************
  typedef struct packed {
    logic        valid;
    logic [31:0] word;
    logic [31:0] pc;
  } rju_req_t;

  typedef struct packed {
    logic        we;
    logic [31:0] target;
  } rju_pc_t;

  typedef enum logic [1:0] {
    RJU_KIND_NONE,
    RJU_KIND_REG,
    RJU_KIND_REL
  } rju_kind_t;

endpackage : rju_pkg

/* File: rju_rf_model.sv */
// Register file model for the jump unit bench.
// Assumes the unit samples the read data on the edge after it sets the read address.
`timescale 1ns/10ps
module rju_rf_model (
  input  wire logic [4:0]  rf_raddr_i, // Read address from the unit.
  output logic      [31:0] rf_rdata_o  // Read data, answered at once.
);
  // ****
  // Contents
  // ****
  // Every register has bit zero set, so a missing alignment mask shows.
  assign rf_rdata_o = {rf_raddr_i, 27'h123_4567};
endmodule : rju_rf_model

/* File: testbench.sv */
// Self-checking bench for the register and relative jump unit.
// Assumes the package and the unit are compiled first.
`timescale 1ns/10ps
module testbench;
  logic              clk_i;
  logic              srst_i;
  rju_pkg::rju_req_t req_i;
  logic              ready_o;
  logic [4:0]        rf_raddr_o;
  logic [31:0]       rf_rdata_i;
  rju_pkg::rju_pc_t  pc_o;
  rju_pkg::rju_kind_t kind_o;
  logic              size32_o;
  logic              other_o;
  logic              flag_we_o;
  int                bad_count;
  int                check_count;
  // ****
  // Design and partner
  // ****
  rju_jump_unit dut (.clk_i(clk_i), .srst_i(srst_i), .req_i(req_i), .ready_o(ready_o),
    .rf_raddr_o(rf_raddr_o), .rf_rdata_i(rf_rdata_i), .pc_o(pc_o), .kind_o(kind_o),
    .size32_o(size32_o), .other_o(other_o), .flag_we_o(flag_we_o));
  rju_rf_model rf (.rf_raddr_i(rf_raddr_o), .rf_rdata_o(rf_rdata_i));
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  // ****
  // Shared tasks
  // ****
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : tally_and_finish
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %0t got %h want %h", $time, seen, exp);
    end
  endtask : check
  // Waits for ready with a bound, presents one word, and returns just after it is taken.
  task automatic issue(input logic [31:0] w, input logic [31:0] p);
    int n;
    n = 0;
    @(negedge clk_i);
    while (ready_o !== 1'b1 && n < 20) begin
      n++;
      @(negedge clk_i);
    end
    if (ready_o !== 1'b1) begin
      bad_count++;
      $display("[FAIL] %0t ready never rose", $time);
      tally_and_finish();
    end else begin
      @(posedge clk_i);
      req_i <= rju_pkg::rju_req_t'{1'b1, w, p};
      @(posedge clk_i);
      req_i.valid <= 1'b0;
      #1;
    end
  endtask : issue
  // Bit 16 of the word is set on purpose: it lies below the stored displacement and must not count.
  task automatic rel_jump(input logic [31:0] p, input logic [21:0] d);
    issue({d[15:1], 1'b1, 10'h01e, d[21:16]}, p);
    check({31'h0, pc_o.we}, 32'h1);
    check(pc_o.target, p + {{10{d[21]}}, d[21:1], 1'b0});
    check({30'h0, kind_o}, {30'h0, rju_pkg::RJU_KIND_REL});
    check({31'h0, size32_o}, 32'h1);
    check({31'h0, flag_we_o}, 32'h0);
  endtask : rel_jump
  // ****
  // Scenarios
  // ****
  task automatic t_reg_jump;
    logic [4:0] r;
    for (int i = 0; i < 4; i++) begin
      r = 5'(i * 10 + 1);
      issue({16'ha5a5, 11'h003, r}, 32'h0000_1000);
      check({27'h0, rf_raddr_o}, {27'h0, r});
      check({31'h0, ready_o}, 32'h0);
      @(posedge clk_i);
      #1;
      check({31'h0, pc_o.we}, 32'h1);
      check(pc_o.target, {r, 27'h123_4567} & 32'hffff_fffe);
      check({30'h0, kind_o}, {30'h0, rju_pkg::RJU_KIND_REG});
      check({31'h0, ready_o}, 32'h1);
      check({31'h0, size32_o}, 32'h0);
      check({31'h0, flag_we_o}, 32'h0);
    end
  endtask : t_reg_jump
  task automatic t_rel_range;
    logic [31:0] pcs [4] = '{32'h0000_2000, 32'h0010_0000, 32'h8000_0000, 32'hffff_fff0};
    logic [21:0] ds [4] = '{22'h00_1234, 22'h3f_fffe, 22'h20_0000, 22'h1f_fffe};
    for (int i = 0; i < 4; i++) begin
      rel_jump(pcs[i], ds[i]);
    end
  endtask : t_rel_range
  task automatic t_rel_self;
    rel_jump(32'h0000_4a00, 22'h00_0000);
    check(pc_o.target, 32'h0000_4a00);
  endtask : t_rel_self
  task automatic t_other_word;
    issue(32'h0000_ffff, 32'h0000_3000);
    check({31'h0, other_o}, 32'h1);
    check({31'h0, pc_o.we}, 32'h0);
    check({30'h0, kind_o}, {30'h0, rju_pkg::RJU_KIND_REL});
  endtask : t_other_word
  // ****
  // Main sequence
  // ****
  initial begin
    bad_count = 0;
    check_count = 0;
    srst_i = 1'b1;
    req_i = '0;
    repeat (20) @(posedge clk_i);
    #1;
    check({30'h0, kind_o}, {30'h0, rju_pkg::RJU_KIND_NONE});
    @(posedge clk_i);
    srst_i <= 1'b0;
    t_reg_jump();
    t_rel_range();
    t_rel_self();
    t_other_word();
    tally_and_finish();
  end
endmodule : testbench
